// ---- oss_ctl_model.sv ----
`timescale 1ns/10ps
module oss_ctl_model
	import oss_pkg::*;
(
	input  wire logic                       ref_clk,
	output logic                            s_axi_awvalid,
	input  wire logic                       s_axi_awready,
	output logic [oss_pkg::OSS_AW-1:0]      s_axi_awaddr,
	output logic                            s_axi_wvalid,
	input  wire logic                       s_axi_wready,
	output logic [oss_pkg::OSS_DW-1:0]      s_axi_wdata,
	input  wire logic                       s_axi_bvalid,
	output logic                            s_axi_bready,
	input  wire logic [1:0]                 s_axi_bresp,
	output logic                            s_axi_arvalid,
	input  wire logic                       s_axi_arready,
	output logic [oss_pkg::OSS_AW-1:0]      s_axi_araddr,
	input  wire logic                       s_axi_rvalid,
	output logic                            s_axi_rready,
	input  wire logic [oss_pkg::OSS_DW-1:0] s_axi_rdata,
	input  wire logic [1:0]                 s_axi_rresp
);
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
	end

	// Timeout returns code 2'b11
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		r = 2'b11;
		@(posedge ref_clk);
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		s_axi_awaddr <= a;
		s_axi_wdata  <= d;
		for (int i = 0; i < 64 && r === 2'b11; i++) begin
			@(posedge ref_clk);
			if (s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr  <= ~a;
			end
			if (s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata  <= ~d;
			end
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				r = s_axi_bresp;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		r = 2'b11;
		@(posedge ref_clk);
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		s_axi_araddr <= a;
		for (int i = 0; i < 64 && r === 2'b11; i++) begin
			@(posedge ref_clk);
			if (s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr  <= ~a;
			end
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				d = s_axi_rdata;
				r = s_axi_rresp;
			end
		end
	endtask
endmodule // oss_ctl_model

// ---- oss_evt_if.sv ----
`timescale 1ns/10ps
interface oss_evt_if;
	logic [oss_pkg::OSS_W-1:0] cond;
	logic                      clr;
	logic [oss_pkg::OSS_W-1:0] evt;

	modport src (output cond, output clr, input evt);
	modport lat (input cond, input clr, output evt);
endinterface

// ---- oss_evt_latch.sv ----
`timescale 1ns/10ps
module oss_evt_latch (
	input  wire logic ref_clk,
	input  wire logic rst,
	oss_evt_if.lat    ev
);
	import oss_pkg::*;

	logic [OSS_W-1:0] prev_r;
	logic [OSS_W-1:0] evt_r;
	logic [OSS_W-1:0] rise;
	logic [OSS_W-1:0] evt_nxt;

	// Rising condition sets its bit
	assign rise    = ev.cond & ~prev_r; // RL9
	// Set wins over a simultaneous clear
	assign evt_nxt = (evt_r & ~{OSS_W{ev.clr}}) | rise; // RL1
	assign ev.evt  = evt_r;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prev_r <= OSS_EVT_RST;
			evt_r  <= OSS_EVT_RST;
		end else begin
			prev_r <= ev.cond;
			evt_r  <= evt_nxt;
		end
	end
endmodule // oss_evt_latch

// ---- oss_pkg.sv ----
package oss_pkg;

	localparam int unsigned OSS_W        = 16;
	localparam int unsigned OSS_AW       = 8;
	localparam int unsigned OSS_DW       = 32;

	// Register byte offsets
	localparam logic [7:0] OSS_OPER_COND_OFS = 8'h00;
	localparam logic [7:0] OSS_OPER_EVT_OFS  = 8'h04;
	localparam logic [7:0] OSS_OPER_ENA_OFS  = 8'h08;
	localparam logic [7:0] OSS_QUES_COND_OFS = 8'h0c;
	localparam logic [7:0] OSS_QUES_EVT_OFS  = 8'h10;
	localparam logic [7:0] OSS_QUES_ENA_OFS  = 8'h14;
	localparam logic [7:0] OSS_STB_OFS       = 8'h18;
	localparam logic [7:0] OSS_CMD_OFS       = 8'h1c;

	// Command register bits
	localparam int unsigned OSS_CMD_PRESET_BIT = 0;
	localparam int unsigned OSS_CMD_CLEAR_BIT  = 1;

	// Operation bit: waiting for trigger, weight 32
	localparam int unsigned OSS_OPER_WTRIG_BIT = 5;

	// Status byte bit positions
	localparam int unsigned OSS_STB_QUES_BIT = 3;
	localparam int unsigned OSS_STB_RQS_BIT  = 6;
	localparam int unsigned OSS_STB_OPER_BIT = 7;
	localparam int unsigned OSS_STB_W        = 8;

	localparam logic [OSS_W-1:0]      OSS_ENA_RST = 16'h0000;
	localparam logic [OSS_W-1:0]      OSS_EVT_RST = 16'h0000;
	localparam logic [OSS_STB_W-1:0]  OSS_STB_RST = 8'h00;
	localparam logic [OSS_DW-1:0]     OSS_DATA_RST = 32'h0000_0000;

	localparam logic [1:0] OSS_RESP_OKAY   = 2'b00;
	localparam logic [1:0] OSS_RESP_SLVERR = 2'b10;

endpackage

// ---- oss_top.sv ----
// Contract
// (RL1) Event bits latch until explicitly cleared
// (RL2) Preset clears status and all enables
// (RL3) Status byte bit 7 summarises enabled operation
// (RL4) Operation bit 5 means waiting for trigger
// (RL5) Enable mask survives clear-all commands
// (RL6) Status byte bit 6 summarises other bits
// (RL7) Controller masks status byte per bit
// (RL8) Controller clears events before each operation; the testbench clears them before some steps only
// (RL9) Events set on rising edge; condition live
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
module oss_top (
	input  wire logic                       ref_clk,
	input  wire logic                       rst,
	input  wire logic [oss_pkg::OSS_W-1:0]  oper_cond,
	input  wire logic [oss_pkg::OSS_W-1:0]  ques_cond,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [oss_pkg::OSS_AW-1:0] s_axi_awaddr,
	input  wire logic [2:0]                 s_axi_awprot,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	input  wire logic [oss_pkg::OSS_DW-1:0] s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	output logic [1:0]                      s_axi_bresp,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	input  wire logic [oss_pkg::OSS_AW-1:0] s_axi_araddr,
	input  wire logic [2:0]                 s_axi_arprot,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output logic [oss_pkg::OSS_DW-1:0]      s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic [oss_pkg::OSS_STB_W-1:0]   status_byte
);
	import oss_pkg::*;

	oss_evt_if oper_if ();
	oss_evt_if ques_if ();

	// Bus handshake state
	logic                 aw_rdy_r;
	logic                 w_rdy_r;
	logic                 bvalid_r;
	logic [1:0]           bresp_r;
	logic                 ar_rdy_r;
	logic                 rvalid_r;
	logic [OSS_DW-1:0]    rdata_r;
	logic [1:0]           rresp_r;
	logic [OSS_AW-1:0]    waddr_r;
	logic [OSS_DW-1:0]    wdata_r;
	logic [3:0]           wstrb_r;

	// Status state
	logic [OSS_W-1:0]     oper_ena_r;
	logic [OSS_W-1:0]     ques_ena_r;
	logic [OSS_STB_W-1:0] stb_r;

	logic                 aw_take;
	logic                 w_take;
	logic                 wr_fire;
	logic                 b_done;
	logic                 ar_take;
	logic                 r_done;
	logic                 wr_hit_oper_ena;
	logic                 wr_hit_ques_ena;
	logic                 wr_hit_cmd;
	logic                 wr_mapped;
	logic                 do_preset;
	logic                 do_clear;
	logic [OSS_W-1:0]     wmask;
	logic [OSS_W-1:0]     oper_ena_nxt;
	logic [OSS_W-1:0]     ques_ena_nxt;
	logic                 oper_sum;
	logic                 ques_sum;
	logic [OSS_STB_W-1:0] stb_nxt;
	logic                 rd_mapped;
	logic [OSS_DW-1:0]    rdata_nxt;

	assign aw_take = s_axi_awvalid & aw_rdy_r;
	assign w_take  = s_axi_wvalid & w_rdy_r;
	// Both address and data held, response not yet out
	assign wr_fire = ~aw_rdy_r & ~w_rdy_r & ~bvalid_r;
	assign b_done  = bvalid_r & s_axi_bready;
	assign ar_take = s_axi_arvalid & ar_rdy_r;
	assign r_done  = rvalid_r & s_axi_rready;

	assign wr_hit_oper_ena = (waddr_r == OSS_OPER_ENA_OFS);
	assign wr_hit_ques_ena = (waddr_r == OSS_QUES_ENA_OFS);
	assign wr_hit_cmd      = (waddr_r == OSS_CMD_OFS);
	assign wr_mapped       = wr_hit_oper_ena | wr_hit_ques_ena | wr_hit_cmd;

	assign do_preset = wr_fire & wr_hit_cmd & wstrb_r[0] & wdata_r[OSS_CMD_PRESET_BIT];
	assign do_clear  = wr_fire & wr_hit_cmd & wstrb_r[0] & wdata_r[OSS_CMD_CLEAR_BIT];

	assign wmask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

	// Preset zeroes every enable; clear-all leaves enables alone
	assign oper_ena_nxt = do_preset ? OSS_ENA_RST :                         // RL2 RL5
		(wr_fire & wr_hit_oper_ena) ?
		((oper_ena_r & ~wmask) | (wdata_r[OSS_W-1:0] & wmask)) : oper_ena_r; // RL4
	assign ques_ena_nxt = do_preset ? OSS_ENA_RST :                         // RL2
		(wr_fire & wr_hit_ques_ena) ?
		((ques_ena_r & ~wmask) | (wdata_r[OSS_W-1:0] & wmask)) : ques_ena_r;

	// Preset and clear-all both empty the event registers
	assign oper_if.cond = oper_cond; // RL4
	assign oper_if.clr  = do_preset | do_clear; // RL1 RL2
	assign ques_if.cond = ques_cond;
	assign ques_if.clr  = do_preset | do_clear; // RL2

	assign oper_sum = |(oper_if.evt & oper_ena_r); // RL3
	assign ques_sum = |(ques_if.evt & ques_ena_r);

	always_comb begin
		stb_nxt                   = OSS_STB_RST;
		stb_nxt[OSS_STB_OPER_BIT] = oper_sum; // RL3
		stb_nxt[OSS_STB_QUES_BIT] = ques_sum;
		stb_nxt[OSS_STB_RQS_BIT]  = oper_sum | ques_sum; // RL6
	end

	assign rd_mapped = (s_axi_araddr == OSS_OPER_COND_OFS) |
		(s_axi_araddr == OSS_OPER_EVT_OFS) | (s_axi_araddr == OSS_OPER_ENA_OFS) |
		(s_axi_araddr == OSS_QUES_COND_OFS) | (s_axi_araddr == OSS_QUES_EVT_OFS) |
		(s_axi_araddr == OSS_QUES_ENA_OFS) | (s_axi_araddr == OSS_STB_OFS) |
		(s_axi_araddr == OSS_CMD_OFS);

	// Condition reads return the live, unlatched input
	assign rdata_nxt =
		(s_axi_araddr == OSS_OPER_COND_OFS) ? {16'h0000, oper_cond} : // RL9
		(s_axi_araddr == OSS_OPER_EVT_OFS)  ? {16'h0000, oper_if.evt} :
		(s_axi_araddr == OSS_OPER_ENA_OFS)  ? {16'h0000, oper_ena_r} :
		(s_axi_araddr == OSS_QUES_COND_OFS) ? {16'h0000, ques_cond} :
		(s_axi_araddr == OSS_QUES_EVT_OFS)  ? {16'h0000, ques_if.evt} :
		(s_axi_araddr == OSS_QUES_ENA_OFS)  ? {16'h0000, ques_ena_r} :
		(s_axi_araddr == OSS_STB_OFS)       ? {24'h00_0000, stb_r} :
		OSS_DATA_RST;

	oss_evt_latch u_oper (
		.ref_clk (ref_clk),
		.rst     (rst),
		.ev      (oper_if.lat)
	);

	oss_evt_latch u_ques (
		.ref_clk (ref_clk),
		.rst     (rst),
		.ev      (ques_if.lat)
	);

	// Write address and data, taken in either order
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			aw_rdy_r <= 1'b1;
			waddr_r  <= 8'h00;
		end else if (aw_take) begin
			aw_rdy_r <= 1'b0;
			waddr_r  <= s_axi_awaddr;
		end else if (b_done) begin
			aw_rdy_r <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			w_rdy_r <= 1'b1;
			wdata_r <= OSS_DATA_RST;
			wstrb_r <= 4'h0;
		end else if (w_take) begin
			w_rdy_r <= 1'b0;
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
		end else if (b_done) begin
			w_rdy_r <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bvalid_r <= 1'b0;
			bresp_r  <= OSS_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_mapped ? OSS_RESP_OKAY : OSS_RESP_SLVERR;
		end else if (b_done) begin
			bvalid_r <= 1'b0;
		end
	end

	// Read channel
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ar_rdy_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r  <= OSS_DATA_RST;
			rresp_r  <= OSS_RESP_OKAY;
		end else if (ar_take) begin
			ar_rdy_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r  <= rdata_nxt;
			rresp_r  <= rd_mapped ? OSS_RESP_OKAY : OSS_RESP_SLVERR;
		end else if (r_done) begin
			ar_rdy_r <= 1'b1;
			rvalid_r <= 1'b0;
		end
	end

	// Enables and status byte
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			oper_ena_r <= OSS_ENA_RST;
			ques_ena_r <= OSS_ENA_RST;
			stb_r      <= OSS_STB_RST;
		end else begin
			oper_ena_r <= oper_ena_nxt; // RL5
			ques_ena_r <= ques_ena_nxt;
			stb_r      <= stb_nxt; // RL3 RL6
		end
	end

	assign s_axi_awready = aw_rdy_r;
	assign s_axi_wready  = w_rdy_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = ar_rdy_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign status_byte   = stb_r;

endmodule // oss_top

// ---- oss_top_asserts.sv ----
`timescale 1ns/10ps
module oss_top_asserts
	import oss_pkg::*;
(
	input wire logic                       ref_clk,
	input wire logic                       rst,
	input wire logic [oss_pkg::OSS_W-1:0]  oper_cond,
	input wire logic                       s_axi_awvalid,
	input wire logic                       s_axi_awready,
	input wire logic [oss_pkg::OSS_AW-1:0] s_axi_awaddr,
	input wire logic                       s_axi_wvalid,
	input wire logic                       s_axi_wready,
	input wire logic [oss_pkg::OSS_DW-1:0] s_axi_wdata,
	input wire logic                       s_axi_arvalid,
	input wire logic                       s_axi_arready,
	input wire logic [oss_pkg::OSS_AW-1:0] s_axi_araddr,
	input wire logic [oss_pkg::OSS_DW-1:0] s_axi_rdata,
	input wire logic [oss_pkg::OSS_STB_W-1:0] status_byte
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence cmd_wr(int b);
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
			s_axi_awaddr == OSS_CMD_OFS && s_axi_wdata[b];
	endsequence

	stb_rqs_a: assert property (status_byte[OSS_STB_RQS_BIT] ==
		(status_byte[OSS_STB_OPER_BIT] || status_byte[OSS_STB_QUES_BIT])) else $error("rqs bad");
	stb_unused_a: assert property ((status_byte & 8'h37) == 8'h00) else $error("stb bits");
	preset_zero_a: assert property (cmd_wr(OSS_CMD_PRESET_BIT) |-> ##3 status_byte == 8'h00)
		else $error("preset left status");
	evt_hold_a: assert property (status_byte[7] && s_axi_awready && $past(s_axi_awready)
		|=> status_byte[7]) else $error("summary dropped");
	clr_all_a: assert property (cmd_wr(OSS_CMD_CLEAR_BIT) ##1 $stable(oper_cond)
		|-> ##2 !status_byte[7]) else $error("clear ignored");
	op_rise_a: assert property ($rose(status_byte[7]) && $past(s_axi_awready) |->
		($past(oper_cond, 2) & ~$past(oper_cond, 3)) != 16'h0000) else $error("summary no cause");
	cond_live_a: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == OSS_OPER_COND_OFS |=> s_axi_rdata == {16'h0000, $past(oper_cond)})
		else $error("cond not live");
endmodule // oss_top_asserts

bind oss_top oss_top_asserts u_oss_top_asserts (.ref_clk, .rst, .oper_cond, .s_axi_awvalid,
	.s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_arvalid,
	.s_axi_arready, .s_axi_araddr, .s_axi_rdata, .status_byte);

// ---- test_operation_status_summary.sv ----
`timescale 1ns/10ps
module test_operation_status_summary;
	import oss_pkg::*;
	logic ref_clk = 1'b0, rst = 1'b1, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, status_byte;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed = 32'h30, d, v;
	logic [15:0] oper_cond = 16'h0, ques_cond = 16'h0, evt, qevt, ena, qena, prv, qprv;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	int          n_errors = 0;
	int          checks = 0;

	oss_top u_oss_top (.ref_clk, .rst, .oper_cond, .ques_cond, .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
		.s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp, .status_byte);
	oss_ctl_model u_oss_ctl_model (.ref_clk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp);

	initial forever #4 ref_clk = ~ref_clk;

	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function logic [7:0] exp_stb(input logic [15:0] o, input logic [15:0] q);
		return {|o, |o | |q, 2'b00, |q, 3'b000};
	endfunction

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	task give_verdict();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Only the enables and the command word accept writes
	function logic [1:0] exp_bresp(input logic [7:0] a);
		if (a == OSS_OPER_ENA_OFS || a == OSS_QUES_ENA_OFS || a == OSS_CMD_OFS)
			return OSS_RESP_OKAY;
		return OSS_RESP_SLVERR;
	endfunction

	task wr(input logic [7:0] a, input logic [31:0] x);
		u_oss_ctl_model.wr(a, x, r);
		if (r === 2'b11) begin
			n_errors++;
			give_verdict();
		end
		chk("bresp", {30'h0, r}, {30'h0, exp_bresp(a)});
	endtask

	task rd(input logic [7:0] a);
		u_oss_ctl_model.rd(a, d, r);
		if (r === 2'b11) begin
			n_errors++;
			give_verdict();
		end
	endtask

	// Conditions move once, then the summary is given time to settle
	task step(input logic [15:0] o, input logic [15:0] q);
		@(posedge ref_clk);
		oper_cond <= o;
		ques_cond <= q;
		evt  = evt | (o & ~prv);
		qevt = qevt | (q & ~qprv);
		prv  = o;
		qprv = q;
		repeat (3) @(posedge ref_clk);
		#1 chk("status", status_byte, exp_stb(evt & ena, qevt & qena));
	endtask

	task clear_all();
		wr(OSS_CMD_OFS, 32'h2);
		evt  = 16'h0;
		qevt = 16'h0;
	endtask

	initial begin
		{evt, qevt, ena, qena, prv, qprv} = 96'h0;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		rd(OSS_OPER_ENA_OFS);
		chk("ena reset", d, 32'h0);
		rd(8'h20);
		chk("unmapped", {d[29:0], r}, {30'h0, OSS_RESP_SLVERR});
		wr(8'h20, 32'hffff_ffff);
		wr(OSS_OPER_EVT_OFS, 32'hffff_ffff);
		wr(OSS_CMD_OFS, 32'h1);
		wr(OSS_OPER_ENA_OFS, 32'h20);
		wr(OSS_QUES_ENA_OFS, 32'hffff);
		{ena, qena} = {16'h0020, 16'hffff};
		clear_all();
		step(16'h0020, 16'h0);
		chk("wait trig", (status_byte & 8'h80) != 0, 1);
		step(16'h0000, 16'h0);
		step(16'hffdf, 16'h0);
		rd(OSS_OPER_EVT_OFS);
		chk("event", d, {16'h0, evt});
		clear_all();
		step(16'hffdf, 16'h0);
		rd(OSS_OPER_ENA_OFS);
		chk("ena kept", d, 32'h20);
		for (int i = 0; i < 40; i++) begin
			v = xs();
			wr(OSS_OPER_ENA_OFS, v);
			ena = v[15:0];
			if (v[20])
				clear_all();
			v = xs();
			step(v[15:0], v[31:16]);
			rd(OSS_OPER_EVT_OFS);
			chk("event", d, {16'h0, evt});
		end
		wr(OSS_CMD_OFS, 32'h1);
		{evt, qevt, ena, qena} = 64'h0;
		step(prv, qprv);
		rd(OSS_QUES_ENA_OFS);
		chk("ques ena", d, 32'h0);
		give_verdict();
	end
endmodule // test_operation_status_summary
